// ==== rtl/wpos_map.svh ====
`ifndef WPOS_MAP_SVH
`define WPOS_MAP_SVH

// register byte offsets
`define WPOS_REG_CODE 8'h00
`define WPOS_REG_STATUS 8'h04
`define WPOS_REG_CLEAR 8'h08

// field positions
`define WPOS_CODE_MSB 5
`define WPOS_ST_PEND_LSB 8
`define WPOS_ST_VALVE 16
`define WPOS_ST_FLASH_HI 17
`define WPOS_ST_FLASH_LO 18
`define WPOS_ST_STOP 19
`define WPOS_ST_HOLD 20
`define WPOS_CLR_BIT 0

// reset values
`define WPOS_CODE_RESET 6'h00

// selection codes (decimal values of the two-digit code)
`define WPOS_PO_OFF 6'h00
`define WPOS_PO_WELD 6'h01
`define WPOS_PO_WELD_HOLD 6'h02
`define WPOS_PO_HOLD 6'h03
`define WPOS_PO_OFFTIME 6'h04
`define WPOS_PO_AFTER_OFF 6'h05
`define WPOS_PO_EOS 6'h06
`define WPOS_PO_AIR_OIL 6'h07
`define WPOS_PO_RETRACT 6'h08
`define WPOS_PO_HALF 6'h09
`define WPOS_PO_ANY_ERR 6'h0A
`define WPOS_PO_TEMP 6'h0B
`define WPOS_PO_FLASH 6'h0C
`define WPOS_PO_FLASH_PULSE 6'h0D
`define WPOS_PO_FLASH_STOP 6'h0E
`define WPOS_PO_HW_ERR 6'h0F
`define WPOS_PO_ERR26 6'h10
`define WPOS_PO_GROUP 6'h11
`define WPOS_PO_ERR13 6'h12
`define WPOS_PO_WELD_INH 6'h13
`define WPOS_PO_GOOD_WELD 6'h14
`define WPOS_PO_SER_HILO 6'h16
`define WPOS_PO_SER_CUR 6'h17
`define WPOS_PO_IND_FLASH 6'h18
`define WPOS_PO_IND_EOS 6'h19
`define WPOS_PO_STOP_HOLD 6'h1A
`define WPOS_PO_STOP_PULSE 6'h1B
`define WPOS_PO_GOOD_EOS 6'h1C
`define WPOS_PO_SER_ALL 6'h1D
`define WPOS_PO_PRESS 6'h1E
`define WPOS_PO_PRESS_END 6'h1F
`define WPOS_PO_ANY_STOP 6'h21
`define WPOS_PO_STOP_ONLY 6'h22

// timing
`define WPOS_CLK_KHZ 250000
`define WPOS_PULSE_MS 500

`endif

// ==== rtl/wpos_pkg.sv ====
package wpos_pkg;

	typedef enum logic [2:0] {
		WPOS_PH_IDLE,
		WPOS_PH_SQUEEZE,
		WPOS_PH_WELD,
		WPOS_PH_HOLD,
		WPOS_PH_OFF
	} wpos_phase_t;

	typedef enum logic {
		WPOS_PULSE_IDLE,
		WPOS_PULSE_ON
	} wpos_pulse_t;

	typedef struct packed {
		wpos_phase_t phase;
		logic repeat_mode;
		logic seq_start;
		logic sequence_end;
		logic weld_one_cycle;
	} wpos_seq_t;

	typedef struct packed {
		logic weld_mode;
		logic program_mode;
	} wpos_panel_t;

	typedef struct packed {
		logic any_error;
		logic estop;
		logic hw_fault;
		logic relay_fault;
		logic err26;
		logic err13;
		logic group_fault;
		logic err36;
	} wpos_err_t;

	typedef struct packed {
		logic eval;
		logic hi;
		logic lo;
		logic const_current;
	} wpos_meas_t;

	typedef struct packed {
		logic flash_hi;
		logic flash_lo;
		logic seq_stop;
		logic blocking_delay_en;
		logic half_cycle;
		logic initiate_block;
		logic serial_prep;
		logic serial_all;
		logic show_current;
	} wpos_ind_t;

endpackage

// ==== rtl/wpos_top.sv ====
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "wpos_map.svh"
// Notes on behaviour
// - code 01 drives valve during weld time regardless of weld/no-weld.
// - code 02 valve during weld and hold; code 03 only during hold.
// - code 04 valve during off time, only in repeat sequences.
// - code 05 valve on after off time until all initiations released.
// - code 06 valve on for half a second at sequence end.
// - code 07 enables the blocking-delay parameter.
// - code 10 valve on for any error, no-weld, program, current out of window in constant-current mode.
// - code 11 valve on while temperature limit switch is open.
// - code 12 flashes HI/LO on out-of-window current, valve untouched.
// - code 13 flashes HI/LO and pulses valve half a second.
// - code 14 flashes HI/LO and stops the sequence.
// - code 15 valve on for hardware or control-relay fault.
// - code 16 valve on error 26; code 18 valve on error 13.
// - code 17 valve on grouped faults.
// - code 19 valve during weld only in weld mode with inhibit closed.
// - codes 28/20 half-second pulse when window, weld mode, inhibit were good.
// - codes 22, 23, 29 prepare HI/LO and current results for serial link.
// - codes 24, 25 indicate sequence end, then show current; only code 24 indicates HI/LO.
// - code 26 flash, stop, valve held; code 27 flash, stop, pulse.
// - code 30 valve on error 36; code 31 checks it at weld end only.
// - code 33 any-error behaviour plus estop plus flash, stop, pulse.
// - code 34 flash, stop and pulse without any-error indication.
// - code 08 toggles valve on aux switch closure, blocks initiation while off.
// - code 09 with one-cycle weld selects half-cycle mode.
module wpos_top
	import wpos_pkg::*;
#(
	parameter int PULSE_CYC = `WPOS_PULSE_MS * `WPOS_CLK_KHZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire wpos_seq_t seq,
	input wire wpos_panel_t panel,
	input wire wpos_err_t err,
	input wire wpos_meas_t meas,
	input wire logic external_inhibit_input,
	input wire logic temperature_limit_switch,
	input wire logic initiation_input_a,
	input wire logic initiation_input_b,
	input wire logic initiation_input_c,
	input wire logic aux_switch_input,
	output logic aux_valve_output,
	output wpos_ind_t ind
);

	localparam int NPIN = 6;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;
	logic [NPIN-1:0] pin_q;
	logic inhibit_closed;
	logic temp_open;
	logic init_any;
	logic aux_closed;
	logic aux_prev_q;

	logic [5:0] pend_code_q;
	logic [5:0] code_q;
	logic ap_wr_q;
	logic ap_rd;
	logic [7:0] ap_addr_q;
	logic ap_take;
	logic clr_wr;
	logic [31:0] rd_mux;
	logic hreadyout_q;
	logic [31:0] hrdata_q;

	wpos_phase_t phase_prev_q;
	logic weld_end;
	logic off_end;
	logic oow_ev;
	logic oow_seen_q;
	logic good;
	logic after_off_q;
	logic toggle_q;
	logic press_end_q;
	logic hold_q;
	logic flash_hi_q;
	logic flash_lo_q;
	logic stop_q;
	logic flash_code;
	logic stop_code;
	logic pulse_code;
	logic any_err_lvl;
	logic trig;
	logic level;
	wpos_pulse_t pulse_st_q;
	logic [26:0] pulse_cnt_q;
	logic valve_q;
	wpos_ind_t ind_d;
	wpos_ind_t ind_q;

	// pin synchronisers: three stages, change taken once stages two and three agree
	assign pin_raw = {aux_switch_input, initiation_input_c, initiation_input_b,
		initiation_input_a, temperature_limit_switch, external_inhibit_input};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge mclk) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						pin_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	assign inhibit_closed = pin_q[0];
	assign temp_open = pin_q[1];
	assign init_any = |pin_q[4:2];
	assign aux_closed = pin_q[5];

	// bus slave: zero wait state, read data fetched in the address phase
	assign ap_take = hsel && hready && htrans[1];
	assign ap_rd = ap_take && !hwrite;
	assign clr_wr = ap_wr_q && (ap_addr_q == `WPOS_REG_CLEAR) && hwdata[`WPOS_CLR_BIT];

	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			`WPOS_REG_CODE: begin
				rd_mux[`WPOS_CODE_MSB:0] = pend_code_q;
			end
			`WPOS_REG_STATUS: begin
				rd_mux[`WPOS_CODE_MSB:0] = code_q;
				rd_mux[`WPOS_ST_PEND_LSB +: 6] = pend_code_q;
				rd_mux[`WPOS_ST_VALVE] = valve_q;
				rd_mux[`WPOS_ST_FLASH_HI] = flash_hi_q;
				rd_mux[`WPOS_ST_FLASH_LO] = flash_lo_q;
				rd_mux[`WPOS_ST_STOP] = stop_q;
				rd_mux[`WPOS_ST_HOLD] = hold_q;
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
		if (haddr[31:8] != 24'h000000) begin
			rd_mux = 32'h00000000;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b1;
		end else begin
			hreadyout_q <= 1'b1;
			ap_wr_q <= ap_take && hwrite && (haddr[31:8] == 24'h000000);
			if (ap_take) begin
				ap_addr_q <= haddr[7:0];
			end
			if (ap_rd) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = 1'b0;

	// stored code vs active code
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend_code_q <= `WPOS_CODE_RESET;
			code_q <= `WPOS_CODE_RESET;
		end else begin
			if (ap_wr_q && ap_addr_q == `WPOS_REG_CODE) begin
				pend_code_q <= hwdata[`WPOS_CODE_MSB:0];
			end
			// code at sequence start
			// switching mid-sequence would cut a running phase output short
			if (seq.seq_start) begin
				code_q <= pend_code_q;
			end
		end
	end

	// sequence events
	assign weld_end = (phase_prev_q == WPOS_PH_WELD) && (seq.phase != WPOS_PH_WELD);
	assign off_end = (phase_prev_q == WPOS_PH_OFF) && (seq.phase != WPOS_PH_OFF);
	assign oow_ev = meas.eval && (meas.hi || meas.lo);
	assign good = !oow_seen_q && panel.weld_mode && inhibit_closed;

	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_prev_q <= WPOS_PH_IDLE;
			oow_seen_q <= 1'b0;
		end else begin
			phase_prev_q <= seq.phase;
			if (oow_ev) begin
				oow_seen_q <= 1'b1;
			end else if (seq.seq_start) begin
				oow_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			after_off_q <= 1'b0;
		end else if (code_q == `WPOS_PO_AFTER_OFF && off_end) begin
			after_off_q <= 1'b1;
		end else if (!init_any || code_q != `WPOS_PO_AFTER_OFF) begin
			after_off_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aux_prev_q <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			aux_prev_q <= aux_closed;
			if (code_q != `WPOS_PO_RETRACT) begin
				toggle_q <= 1'b0;
			end else if (aux_closed && !aux_prev_q) begin
				toggle_q <= !toggle_q;
			end
		end
	end

	// pressure error sampled at weld end
	always_ff @(posedge mclk) begin
		if (rst) begin
			press_end_q <= 1'b0;
		end else if (weld_end && err.err36) begin
			press_end_q <= 1'b1;
		end else if (seq.seq_start) begin
			press_end_q <= 1'b0;
		end
	end

	// out-of-window code classes
	// code 34 stop pulse
	assign flash_code = (code_q == `WPOS_PO_FLASH) || (code_q == `WPOS_PO_FLASH_PULSE) ||
		(code_q == `WPOS_PO_FLASH_STOP) || (code_q == `WPOS_PO_IND_FLASH) ||
		(code_q == `WPOS_PO_STOP_HOLD) || (code_q == `WPOS_PO_STOP_PULSE) ||
		(code_q == `WPOS_PO_ANY_STOP) || (code_q == `WPOS_PO_STOP_ONLY);
	assign stop_code = (code_q == `WPOS_PO_FLASH_STOP) || (code_q == `WPOS_PO_STOP_HOLD) ||
		(code_q == `WPOS_PO_STOP_PULSE) || (code_q == `WPOS_PO_ANY_STOP) ||
		(code_q == `WPOS_PO_STOP_ONLY);
	assign pulse_code = (code_q == `WPOS_PO_FLASH_PULSE) || (code_q == `WPOS_PO_STOP_PULSE) ||
		(code_q == `WPOS_PO_ANY_STOP) || (code_q == `WPOS_PO_STOP_ONLY);

	// flash latches, cleared by software; a new event wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			flash_hi_q <= 1'b0;
			flash_lo_q <= 1'b0;
		end else begin
			if (flash_code && meas.eval && meas.hi) begin
				flash_hi_q <= 1'b1;
			end else if (clr_wr) begin
				flash_hi_q <= 1'b0;
			end
			if (flash_code && meas.eval && meas.lo) begin
				flash_lo_q <= 1'b1;
			end else if (clr_wr) begin
				flash_lo_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stop_q <= 1'b0;
		end else if (stop_code && oow_ev) begin
			stop_q <= 1'b1;
		end else if (clr_wr) begin
			stop_q <= 1'b0;
		end
	end

	// code 26 valve held until cleared or emergency stop
	always_ff @(posedge mclk) begin
		if (rst) begin
			hold_q <= 1'b0;
		end else if (code_q == `WPOS_PO_STOP_HOLD && oow_ev) begin
			hold_q <= 1'b1;
		end else if (clr_wr || err.estop) begin
			hold_q <= 1'b0;
		end
	end

	assign any_err_lvl = err.any_error || !panel.weld_mode || panel.program_mode ||
		(meas.const_current && oow_seen_q);

	// half-second pulse triggers
	always_comb begin
		trig = 1'b0;
		if (code_q == `WPOS_PO_EOS && seq.sequence_end) begin
			trig = 1'b1;
		end
		if (pulse_code && oow_ev) begin
			trig = 1'b1;
		end
		if (code_q == `WPOS_PO_GOOD_EOS && seq.sequence_end && good) begin
			trig = 1'b1;
		end
		if (code_q == `WPOS_PO_GOOD_WELD && weld_end && good) begin
			trig = 1'b1;
		end
		if ((code_q == `WPOS_PO_IND_FLASH || code_q == `WPOS_PO_IND_EOS) && seq.sequence_end) begin
			trig = 1'b1;
		end
	end

	// pulse timer, retrigger restarts the half second
	always_ff @(posedge mclk) begin
		if (rst) begin
			pulse_st_q <= WPOS_PULSE_IDLE;
			pulse_cnt_q <= 27'h0000000;
		end else begin
			case (pulse_st_q)
				WPOS_PULSE_IDLE: begin
					if (trig) begin
						pulse_st_q <= WPOS_PULSE_ON;
						pulse_cnt_q <= 27'(PULSE_CYC - 1);
					end
				end
				WPOS_PULSE_ON: begin
					if (trig) begin
						pulse_cnt_q <= 27'(PULSE_CYC - 1);
					end else if (pulse_cnt_q == 27'h0000000) begin
						pulse_st_q <= WPOS_PULSE_IDLE;
					end else begin
						pulse_cnt_q <= pulse_cnt_q - 27'h0000001;
					end
				end
				default: begin
					pulse_st_q <= WPOS_PULSE_IDLE;
				end
			endcase
		end
	end

	// level selection per code
	always_comb begin
		level = 1'b0;
		case (code_q)
			`WPOS_PO_WELD: level = (seq.phase == WPOS_PH_WELD);
			`WPOS_PO_WELD_HOLD: level = (seq.phase == WPOS_PH_WELD) || (seq.phase == WPOS_PH_HOLD);
			`WPOS_PO_HOLD: level = (seq.phase == WPOS_PH_HOLD);
			`WPOS_PO_OFFTIME: level = (seq.phase == WPOS_PH_OFF) && seq.repeat_mode;
			`WPOS_PO_AFTER_OFF: level = after_off_q;
			`WPOS_PO_RETRACT: level = toggle_q;
			`WPOS_PO_ANY_ERR: level = any_err_lvl;
			`WPOS_PO_TEMP: level = temp_open;
			`WPOS_PO_HW_ERR: level = err.hw_fault || err.relay_fault;
			`WPOS_PO_ERR26: level = err.err26;
			`WPOS_PO_ERR13: level = err.err13;
			`WPOS_PO_GROUP: level = err.group_fault;
			`WPOS_PO_WELD_INH: level = (seq.phase == WPOS_PH_WELD) && panel.weld_mode && inhibit_closed;
			`WPOS_PO_STOP_HOLD: level = hold_q;
			`WPOS_PO_PRESS: level = err.err36;
			`WPOS_PO_PRESS_END: level = press_end_q;
			`WPOS_PO_ANY_STOP: level = any_err_lvl || err.estop;
			default: level = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			valve_q <= 1'b0;
		end else begin
			valve_q <= level || (pulse_st_q == WPOS_PULSE_ON);
		end
	end

	// side indications
	always_comb begin
		ind_d = '0;
		ind_d.flash_hi = flash_hi_q;
		ind_d.flash_lo = flash_lo_q;
		ind_d.seq_stop = stop_q;
		ind_d.blocking_delay_en = (code_q == `WPOS_PO_AIR_OIL);
		ind_d.half_cycle = (code_q == `WPOS_PO_HALF) && seq.weld_one_cycle;
		ind_d.initiate_block = (code_q == `WPOS_PO_RETRACT) && !toggle_q;
		ind_d.serial_prep = meas.eval && ((code_q == `WPOS_PO_SER_HILO) ||
			(code_q == `WPOS_PO_SER_CUR) || (code_q == `WPOS_PO_SER_ALL));
		ind_d.serial_all = (code_q == `WPOS_PO_SER_ALL);
		ind_d.show_current = ind_q.show_current;
		if ((code_q == `WPOS_PO_IND_FLASH || code_q == `WPOS_PO_IND_EOS) && seq.sequence_end) begin
			ind_d.show_current = 1'b1;
		end else if (seq.seq_start) begin
			ind_d.show_current = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ind_q <= '0;
		end else begin
			ind_q <= ind_d;
		end
	end

	assign aux_valve_output = valve_q;
	assign ind = ind_q;

endmodule

// ==== dv/wpos_properties.sv ====
`timescale 1ns/10ps
module wpos_properties
	import wpos_pkg::*;
#(
	parameter int PULSE_CYC = 20
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire wpos_seq_t seq,
	input wire wpos_err_t err,
	input wire wpos_meas_t meas,
	input wire logic temperature_limit_switch,
	input wire logic aux_valve_output,
	input wire wpos_ind_t ind
);
	logic wr_q;
	logic [5:0] pend_q;
	logic [5:0] act_q;
	int run_q;
	// shadow of the code: a stored code waits for the next start
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_q <= 1'b0;
			pend_q <= 6'h00;
			act_q <= 6'h00;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0000;
			if (wr_q) begin
				pend_q <= hwdata[5:0];
			end
			if (seq.seq_start) begin
				act_q <= pend_q;
			end
		end
	end
	// length of the running high stretch of the valve
	always_ff @(posedge mclk) begin
		if (rst) begin
			run_q <= 0;
		end else begin
			run_q <= aux_valve_output ? run_q + 1 : 0;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	AST_WELD: assert property (act_q == 6'h01 |=> aux_valve_output == $past(seq.phase == WPOS_PH_WELD))
		else $error("valve not following weld");
	AST_EOS_ON: assert property (act_q == 6'h06 && seq.sequence_end |-> ##2 aux_valve_output)
		else $error("valve not on after end");
	AST_PULSE_LEN: assert property ($fell(aux_valve_output) && act_q inside {6'h06, 6'h0D}
		|-> run_q == PULSE_CYC)
		else $error("valve pulse length wrong");
	AST_TEMP: assert property ((act_q == 6'h0B && $stable(temperature_limit_switch)) [*6]
		|=> aux_valve_output == $past(temperature_limit_switch))
		else $error("valve not following switch");
	AST_FLASH_ONLY: assert property (act_q == 6'h0C |=> !aux_valve_output)
		else $error("valve driven by flash code");
	AST_STOP: assert property (act_q == 6'h0E && meas.eval && (meas.hi || meas.lo)
		|-> ##2 ind.seq_stop && ind.flash_lo == $past(meas.lo, 2) && !aux_valve_output)
		else $error("stop not raised");
	AST_ERR26: assert property (act_q == 6'h10 |=> aux_valve_output == $past(err.err26))
		else $error("valve not following fault");
	AST_IDLE_CODES: assert property (act_q inside {6'h00, 6'h15, 6'h20, [6'h23:6'h3F]} |=> !aux_valve_output)
		else $error("valve on for idle code");
endmodule

bind wpos_top wpos_properties #(.PULSE_CYC(PULSE_CYC)) i_wpos_properties (.mclk(mclk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .seq(seq), .err(err),
	.meas(meas), .temperature_limit_switch(temperature_limit_switch), .aux_valve_output(aux_valve_output),
	.ind(ind));

// ==== dv/wpos_plc.sv ====
`timescale 1ns/10ps
module wpos_plc (
	input wire logic mclk,
	input wire logic rst,
	input wire logic aux_valve_output,
	input wire logic req,
	input wire logic slow,
	output logic init_q,
	output int last_on_q
);
	int run_q;
	// holds initiation until the valve answers; a slow machine lingers
	always @(posedge mclk) begin
		if (rst) begin
			init_q <= 1'b0;
			run_q <= 0;
			last_on_q <= 0;
		end else begin
			run_q <= aux_valve_output ? run_q + 1 : 0;
			if (!aux_valve_output && run_q > 0) begin
				last_on_q <= run_q;
			end
			if (req) begin
				init_q <= 1'b1;
			end else if (aux_valve_output && (!slow || run_q > 10)) begin
				init_q <= 1'b0;
			end
		end
	end
endmodule

// ==== dv/wpos_top_tb.sv ====
`timescale 1ns/10ps
module wpos_top_tb;
	import wpos_pkg::*;
	localparam int PULSE_CYC = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	wpos_seq_t seq = '0;
	wpos_panel_t panel = '0;
	wpos_err_t err = '0;
	wpos_meas_t meas = '0;
	logic inhibit = 1'b0;
	logic temp_sw = 1'b0;
	logic aux_sw = 1'b0;
	logic req = 1'b0;
	logic slow = 1'b0;
	logic init_a;
	logic valve;
	wpos_ind_t ind;
	int last_on;
	int failures = 0;
	int check_count = 0;
	int tc[9] = '{1, 2, 3, 4, 4, 19, 19, 0, 21};
	logic [2:0] tm[9] = '{3'h2, 3'h6, 3'h6, 3'h7, 3'h6, 3'h6, 3'h4, 3'h7, 3'h7};
	int pc[5] = '{6, 28, 20, 13, 27};
	int ec[7] = '{10, 15, 15, 16, 17, 18, 30};
	wpos_err_t eb[7] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h02, 8'h04, 8'h01};

	always #2 mclk = ~mclk;

	wpos_top #(.PULSE_CYC(PULSE_CYC)) i_wpos_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .seq(seq), .panel(panel), .err(err), .meas(meas),
		.external_inhibit_input(inhibit), .temperature_limit_switch(temp_sw), .initiation_input_a(init_a),
		.initiation_input_b(1'b0), .initiation_input_c(1'b0), .aux_switch_input(aux_sw),
		.aux_valve_output(valve), .ind(ind));
	wpos_plc i_wpos_plc (.mclk(mclk), .rst(rst), .aux_valve_output(valve), .req(req), .slow(slow),
		.init_q(init_a), .last_on_q(last_on));

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	// address phase held until hready, then data phase until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic go(input logic [5:0] c);
		bus(1'b1, 8'h00, {26'h0, c});
		@(posedge mclk);
		seq.seq_start <= 1'b1;
		@(posedge mclk);
		seq.seq_start <= 1'b0;
		cyc(2);
	endtask

	task automatic endseq;
		@(posedge mclk);
		seq.sequence_end <= 1'b1;
		@(posedge mclk);
		seq.sequence_end <= 1'b0;
	endtask

	task automatic evl(input logic hi, input logic lo);
		@(posedge mclk);
		meas.eval <= 1'b1;
		meas.hi <= hi;
		meas.lo <= lo;
		@(posedge mclk);
		meas.eval <= 1'b0;
	endtask

	function automatic logic pv(input int c, input wpos_phase_t p);
		case (c)
			1: return p == WPOS_PH_WELD;
			2: return p inside {WPOS_PH_WELD, WPOS_PH_HOLD};
			3: return p == WPOS_PH_HOLD;
			4: return p == WPOS_PH_OFF && seq.repeat_mode;
			19: return p == WPOS_PH_WELD && panel.weld_mode && inhibit;
			default: return 1'b0;
		endcase
	endfunction

	initial begin
		cyc(20000);
		failures++;
		final_report;
	end

	initial begin
		cyc(8);
		rst <= 1'b0;
		meas.const_current <= 1'b1;
		bus(1'b0, 8'h04, 32'h0);
		chk("status", 32'h0, rd);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, 8'h00, 32'hFFFF_FFC5);
		bus(1'b0, 8'h00, 32'h0);
		chk("code", 32'h5, rd);
		bus(1'b0, 8'h04, 32'h0);
		chk("pending", 32'h500, rd);
		foreach (tc[i]) begin
			{panel.weld_mode, inhibit, seq.repeat_mode} <= tm[i];
			cyc(8);
			go(tc[i][5:0]);
			for (int p = 1; p < 5; p++) begin
				seq.phase <= wpos_phase_t'(p);
				cyc(3);
				chk("phase valve", pv(tc[i], wpos_phase_t'(p)), valve);
			end
			seq.phase <= WPOS_PH_IDLE;
		end
		foreach (pc[i]) begin
			go(pc[i][5:0]);
			if (pc[i] == 20) begin
				seq.phase <= WPOS_PH_WELD;
				cyc(2);
				seq.phase <= WPOS_PH_HOLD;
				cyc(1);
			end else if (pc[i] < 13) begin
				endseq();
			end else if (pc[i] == 28) begin
				endseq();
			end else begin
				evl(1'b1, 1'b0);
			end
			cyc(2);
			chk("pulse on", 32'h1, valve);
			chk("stop flash", (pc[i] == 13 || pc[i] == 27) + 2 * (pc[i] == 27), {ind.seq_stop, ind.flash_hi});
			seq.phase <= WPOS_PH_IDLE;
			cyc(PULSE_CYC + 4);
			chk("pulse length", PULSE_CYC, last_on);
			bus(1'b1, 8'h08, 32'h1);
		end
		go(6'h1C);
		evl(1'b0, 1'b1);
		endseq();
		cyc(2);
		chk("bad weld", 32'h0, valve);
		for (int c = 12; c < 15; c += 2) begin
			go(c[5:0]);
			evl(1'b0, 1'b1);
			cyc(2);
			chk("flash stop", (c == 14) ? 32'h6 : 32'h4, {ind.flash_lo, ind.seq_stop, valve});
			bus(1'b1, 8'h08, 32'h1);
			cyc(2);
			chk("cleared", 32'h0, {ind.flash_lo, ind.seq_stop});
		end
		go(6'h1A);
		evl(1'b1, 1'b0);
		cyc(2);
		chk("held", 32'h1, valve);
		err.estop <= 1'b1;
		cyc(3);
		chk("estop", 32'h0, valve);
		err.estop <= 1'b0;
		bus(1'b1, 8'h08, 32'h1);
		go(6'h0B);
		for (int v = 1; v >= 0; v--) begin
			temp_sw <= v[0];
			cyc(8);
			chk("temp", v, valve);
		end
		foreach (ec[i]) begin
			go(ec[i][5:0]);
			err <= eb[i];
			cyc(3);
			chk("fault on", 32'h1, valve);
			err <= '0;
			cyc(3);
			chk("fault off", 32'h0, valve);
		end
		// slow machine keeps initiation so the latch must hold
		slow <= 1'b1;
		req <= 1'b1;
		cyc(1);
		req <= 1'b0;
		go(6'h05);
		seq.phase <= WPOS_PH_OFF;
		cyc(3);
		seq.phase <= WPOS_PH_IDLE;
		cyc(4);
		chk("after off", 32'h1, valve);
		bus(1'b1, 8'h00, 32'h1);
		seq.phase <= WPOS_PH_WELD;
		cyc(30);
		chk("released", 32'h0, valve);
		seq.phase <= WPOS_PH_IDLE;
		go(6'h07);
		chk("blocking delay", 32'h1, ind.blocking_delay_en);
		go(6'h09);
		chk("half idle", 32'h0, ind.half_cycle);
		seq.weld_one_cycle <= 1'b1;
		cyc(3);
		chk("half cycle", 32'h1, ind.half_cycle);
		seq.weld_one_cycle <= 1'b0;
		go(6'h08);
		chk("retract idle", 32'h2, {ind.initiate_block, valve});
		// closures toggle, openings leave the state alone
		for (int t = 0; t < 4; t++) begin
			aux_sw <= (t % 2 == 0);
			cyc(8);
			chk("retract", (t < 2) ? 32'h1 : 32'h2, {ind.initiate_block, valve});
		end
		for (int c = 24; c < 26; c++) begin
			go(c[5:0]);
			chk("no current", 32'h0, ind.show_current);
			endseq();
			cyc(2);
			chk("eos marker", 32'h3, {ind.show_current, valve});
			cyc(PULSE_CYC + 2);
			chk("marker length", PULSE_CYC, last_on);
		end
		go(6'h1D);
		evl(1'b0, 1'b0);
		cyc(1);
		chk("serial prep", 32'h3, {ind.serial_prep, ind.serial_all});
		cyc(1);
		chk("serial done", 32'h1, {ind.serial_prep, ind.serial_all});
		go(6'h1F);
		err.err36 <= 1'b1;
		seq.phase <= WPOS_PH_WELD;
		cyc(3);
		chk("press weld", 32'h0, valve);
		seq.phase <= WPOS_PH_HOLD;
		cyc(3);
		chk("press end", 32'h1, valve);
		err.err36 <= 1'b0;
		seq.phase <= WPOS_PH_IDLE;
		go(6'h22);
		evl(1'b0, 1'b1);
		cyc(2);
		chk("stop only", 32'h7, {ind.flash_lo, ind.seq_stop, valve});
		cyc(PULSE_CYC + 2);
		chk("stop pulse", PULSE_CYC, last_on);
		bus(1'b1, 8'h08, 32'h1);
		go(6'h21);
		for (int v = 1; v >= 0; v--) begin
			err.estop <= v[0];
			cyc(3);
			chk("estop level", v, valve);
		end
		final_report;
	end
endmodule
